// File: rtl/crtc_pkg.sv
// constants shared by the row scan and cursor logic
package crtc_pkg;
  localparam logic [7:0] IDX_PRESET    = 8'h08;
  localparam logic [7:0] IDX_MAXSCAN   = 8'h09;
  localparam logic [7:0] IDX_CUR_START = 8'h0a;
  localparam logic [7:0] IDX_CUR_END   = 8'h0b;
  localparam logic [7:0] IDX_START_HI  = 8'h0c;
  localparam logic [7:0] IDX_START_LO  = 8'h0d;
  localparam logic [7:0] IDX_CUR_HI    = 8'h0e;
  localparam logic [7:0] IDX_CUR_LO    = 8'h0f;
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam int         DBL_BIT       = 7;
  localparam int         LC9_BIT       = 6;
  localparam int         VB9_BIT       = 5;
  localparam int         CUR_OFF_BIT   = 5;
  localparam int         SKEW_LO       = 5;
  localparam int         OVF_LC8_BIT   = 4;
  localparam int         OVF_VB8_BIT   = 3;
  localparam logic [7:0] MASK_PRESET   = 8'h7f;
  localparam logic [7:0] MASK_CUR_ST   = 8'h3f;
  localparam logic [7:0] MASK_CUR_END  = 8'h7f;
  localparam logic [4:0] PAN_STEP_9    = 5'h09;
  localparam logic [4:0] PAN_STEP_8    = 5'h08;
  localparam int         SKEW_DEPTH    = 4;
endpackage

// File: rtl/crtc_regs_if.sv
// register values handed from the register file to the timing logic
interface crtc_regs_if;
  logic [7:0] preset;
  logic [7:0] maxscan;
  logic [7:0] cur_start;
  logic [7:0] cur_end;
  logic [15:0] start_addr;
  logic [15:0] cur_loc;
  modport src (output preset, maxscan, cur_start, cur_end, start_addr, cur_loc);
  modport dst (input preset, maxscan, cur_start, cur_end, start_addr, cur_loc);
endinterface

// File: rtl/crtc_reg_file.sv
// indexed register file behind the crtc data port
module crtc_reg_file
  import crtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] index,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_r,
  crtc_regs_if.src        regs
);
  typedef struct packed {
    logic [7:0] preset;
    logic [7:0] maxscan;
    logic [7:0] cur_start;
    logic [7:0] cur_end;
    logic [7:0] st_hi;
    logic [7:0] st_lo;
    logic [7:0] cl_hi;
    logic [7:0] cl_lo;
    logic [7:0] rdata;
  } rf_t;
  rf_t s_r, s_nxt;

  // write decode, reserved bits held at zero
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      unique case (index)
        IDX_PRESET:    s_nxt.preset    = wdata & MASK_PRESET;
        IDX_MAXSCAN:   s_nxt.maxscan   = wdata;
        IDX_CUR_START: s_nxt.cur_start = wdata & MASK_CUR_ST;
        IDX_CUR_END:   s_nxt.cur_end   = wdata & MASK_CUR_END;
        IDX_START_HI:  s_nxt.st_hi     = wdata;
        IDX_START_LO:  s_nxt.st_lo     = wdata;
        IDX_CUR_HI:    s_nxt.cl_hi     = wdata;
        IDX_CUR_LO:    s_nxt.cl_lo     = wdata;
        default:       s_nxt.rdata     = s_r.rdata;
      endcase
    end
    // read data registered; unmapped indexes read zero
    unique case (index)
      IDX_PRESET:    s_nxt.rdata = s_nxt.preset;
      IDX_MAXSCAN:   s_nxt.rdata = s_nxt.maxscan;
      IDX_CUR_START: s_nxt.rdata = s_nxt.cur_start;
      IDX_CUR_END:   s_nxt.rdata = s_nxt.cur_end;
      IDX_START_HI:  s_nxt.rdata = s_nxt.st_hi;
      IDX_START_LO:  s_nxt.rdata = s_nxt.st_lo;
      IDX_CUR_HI:    s_nxt.rdata = s_nxt.cl_hi;
      IDX_CUR_LO:    s_nxt.rdata = s_nxt.cl_lo;
      default:       s_nxt.rdata = RST_REG;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_r         = s_r.rdata;
  assign regs.preset     = s_r.preset;
  assign regs.maxscan    = s_r.maxscan;
  assign regs.cur_start  = s_r.cur_start;
  assign regs.cur_end    = s_r.cur_end;
  assign regs.start_addr = {s_r.st_hi, s_r.st_lo};
  assign regs.cur_loc    = {s_r.cl_hi, s_r.cl_lo};
endmodule

// File: rtl/crtc_row_scan.sv
// row scan, line compare, blanking start, panning and text cursor
module crtc_row_scan
  import crtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        char_en,
  input  wire logic        line_start,
  input  wire logic        frame_start,
  input  wire logic        line_active,
  input  wire logic [9:0]  line_num,
  input  wire logic [15:0] char_addr,
  input  wire logic        text_mode,
  input  wire logic        nine_dot,
  input  wire logic        nine_dot_disable,
  input  wire logic [7:0]  vertical_overflow_bits,
  input  wire logic [7:0]  vblank_start_low,
  input  wire logic [7:0]  line_compare_low,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_index,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [4:0]  row_scan,
  output logic      [15:0] row_base_addr,
  output logic             addr_restart,
  output logic             vblank_begin,
  output logic      [4:0]  pan_pixels,
  output logic             cursor_pix
);
  crtc_regs_if regs ();

  crtc_reg_file u_regs (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (reg_wr),
    .index   (reg_index),
    .wdata   (reg_wdata),
    .rdata_r (reg_rdata),
    .regs    (regs)
  );

  typedef struct packed {
    logic [4:0]            scan;
    logic                  half;
    logic                  split;
    logic [15:0]           base;
    logic                  restart;
    logic                  vblank;
    logic [4:0]            pan;
    logic [SKEW_DEPTH-1:0] cur_pipe;
    logic                  cursor;
  } st_t;
  st_t s_r, s_nxt;

  logic [9:0] line_cmp;
  logic [9:0] vbl_start;
  logic [1:0] byte_pan;
  logic [1:0] skew;
  logic       cur_on;
  logic       cur_hit;
  logic [4:0] max_scan;

  // ten-bit compare and blanking values
  assign line_cmp  = {regs.maxscan[LC9_BIT], vertical_overflow_bits[OVF_LC8_BIT],
                      line_compare_low};
  assign vbl_start = {regs.maxscan[VB9_BIT], vertical_overflow_bits[OVF_VB8_BIT],
                      vblank_start_low};
  assign byte_pan  = regs.preset[6:5];
  assign skew      = regs.cur_end[SKEW_LO+1:SKEW_LO];
  assign max_scan  = regs.maxscan[4:0];
  // cursor only in text mode, bit 5 low enables
  assign cur_on    = text_mode && !regs.cur_start[CUR_OFF_BIT];
  // inclusive line range inside the box
  assign cur_hit   = cur_on && (char_addr == regs.cur_loc) &&
                     (s_r.scan >= regs.cur_start[4:0]) &&
                     (s_r.scan <= regs.cur_end[4:0]);

  always_comb begin
    s_nxt         = s_r;
    s_nxt.restart = 1'b0;
    s_nxt.vblank  = 1'b0;
    // shift step: nine only for nine-pixel text without disable
    if (text_mode && nine_dot && !nine_dot_disable) begin
      s_nxt.pan = 5'(byte_pan * PAN_STEP_9);
    end else begin
      s_nxt.pan = 5'(byte_pan * PAN_STEP_8);
    end
    if (frame_start) begin
      // top row begins at the preset scan line
      s_nxt.scan  = regs.preset[4:0];
      s_nxt.half  = 1'b0;
      s_nxt.split = 1'b0;
      s_nxt.base  = regs.start_addr;
    end else if (line_start) begin
      // double scan advances the counter on every second line
      s_nxt.half = regs.maxscan[DBL_BIT] ? !s_r.half : 1'b0;
      if (!regs.maxscan[DBL_BIT] || s_r.half) begin
        s_nxt.scan = (s_r.scan >= max_scan) ? 5'h00 : s_r.scan + 5'h01;
      end
      if (line_num == line_cmp && line_active) begin
        s_nxt.split   = 1'b1;
        s_nxt.base    = 16'h0000;
        s_nxt.restart = 1'b1;
      end
      if (line_num == vbl_start) begin
        s_nxt.vblank = 1'b1;
      end
    end
    // skew pipeline, advanced by the character clock
    if (char_en) begin
      s_nxt.cur_pipe = {s_r.cur_pipe[SKEW_DEPTH-2:0], cur_hit};
      s_nxt.cursor   = (skew == 2'b00) ? cur_hit : s_r.cur_pipe[skew - 2'b01];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign row_scan      = s_r.scan;
  assign row_base_addr = s_r.base;
  assign addr_restart  = s_r.restart;
  assign vblank_begin  = s_r.vblank;
  assign pan_pixels    = s_r.pan;
  assign cursor_pix    = s_r.cursor;
endmodule

// File: bench/crtc_row_scan_checker.sv
// port assertions for the row scan block
module crtc_row_scan_checker
  import crtc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        line_start,
  input wire logic        frame_start,
  input wire logic [9:0]  line_num,
  input wire logic [7:0]  vblank_start_low,
  input wire logic [7:0]  line_compare_low,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_index,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] row_base_addr,
  input wire logic        addr_restart,
  input wire logic        vblank_begin,
  input wire logic [4:0]  pan_pixels
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a read shows the index taken one edge earlier, so writes echo then
  chk_start_echo: assert property (reg_wr && reg_index == IDX_START_HI
    |=> reg_rdata == $past(reg_wdata)) else $error("start echo");
  chk_cursor_mask: assert property (reg_wr && reg_index == IDX_CUR_START
    |=> reg_rdata == ($past(reg_wdata) & MASK_CUR_ST)) else $error("cursor bits");
  chk_refused_index: assert property (reg_wr && reg_index > IDX_CUR_LO
    |=> reg_rdata == RST_REG) else $error("refused index");
  chk_restart_cause: assert property (addr_restart
    |-> $past(line_start && line_num[7:0] == line_compare_low)) else $error("restart");
  chk_restart_base: assert property (addr_restart |-> row_base_addr == 16'h0000)
    else $error("restart base");
  chk_vblank_cause: assert property (vblank_begin
    |-> $past(line_num[7:0] == vblank_start_low)) else $error("vblank line");
  chk_base_hold: assert property (!line_start && !frame_start
    |=> $stable(row_base_addr)) else $error("base moved");
  chk_pan_amount: assert property (pan_pixels inside {5'h00, 5'h08, 5'h09, 5'h10,
    5'h12, 5'h18, 5'h1b}) else $error("pan amount");
  cover property (addr_restart);
  cover property (vblank_begin);
  cover property (reg_wr && reg_index == IDX_CUR_LO);
endmodule

bind crtc_row_scan crtc_row_scan_checker crtc_row_scan_checker_inst (
  .clk, .rst_n, .line_start, .frame_start, .line_num, .vblank_start_low,
  .line_compare_low, .reg_wr, .reg_index, .reg_wdata, .reg_rdata, .row_base_addr,
  .addr_restart, .vblank_begin, .pan_pixels);

// File: bench/crtc_row_scan_tb.sv
// self-checking bench for the row scan block
module crtc_row_scan_tb
  import crtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [25:0] RD = 26'h3fc_0000;
  logic        clk, rst_n, line_start, frame_start, reg_wr, probe, nine_dot;
  logic        nine_dot_disable, addr_restart, vblank_begin;
  logic [9:0]  line_num;
  logic [15:0] char_addr, row_base_addr;
  logic [7:0]  vertical_overflow_bits, vblank_start_low, line_compare_low;
  logic [7:0]  reg_index, reg_wdata, reg_rdata, msk;
  logic [31:0] seed, seed2;
  logic [25:0] ev, em;
  logic [51:0] exp_q[$];
  int          num_errors, samples_checked;
  wire  [25:0] obs = {reg_rdata, row_base_addr, addr_restart, vblank_begin};

  crtc_row_scan crtc_row_scan_inst (.clk, .rst_n, .char_en(1'b1), .line_start, .frame_start,
    .line_active(1'b1), .line_num, .char_addr, .text_mode(1'b1), .nine_dot,
    .nine_dot_disable, .vertical_overflow_bits, .vblank_start_low, .line_compare_low,
    .reg_wr, .reg_index, .reg_wdata, .reg_rdata, .row_scan(), .row_base_addr,
    .addr_restart, .vblank_begin, .pan_pixels(), .cursor_pix());

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // clock, plus random pan mode and character address every cycle
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) seed2 <= lfsr(seed2);
  assign {nine_dot, nine_dot_disable, char_addr} = seed2[17:0];

  // one request edge with its note; op is write, frame, line
  task automatic put(input logic [2:0] op, input logic [7:0] idx, d,
                     input logic [9:0] ln, input logic [25:0] v, m);
    @(posedge clk);
    {reg_wr, frame_start, line_start, probe} <= {op, 1'b1};
    {reg_index, reg_wdata, line_num} <= {idx, d, ln};
    exp_q.push_back({v, m});
    @(posedge clk);
    {reg_wr, frame_start, line_start, probe} <= 4'h0;
  endtask

  // compare at the falling edge so the answer edge has fully landed
  always @(posedge clk) begin
    if (probe === 1'b1) begin
      @(negedge clk);
      {ev, em} = exp_q.pop_front();
      samples_checked++;
      if ((obs & em) !== (ev & em)) begin
        num_errors++;
        $display("FAIL %0t got %h want %h", $time, obs & em, ev & em);
      end
    end
  end

  task automatic end_of_test();
    if (exp_q.size() != 0) num_errors++;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (500) @(posedge clk);
    $display("FAIL %0t timeout", $time);
    num_errors++;
    end_of_test();
  end

  // reset, register sweep with refused neighbours, then a split screen frame
  initial begin
    {rst_n, reg_wr, probe, frame_start, line_start} = 5'h00;
    {reg_index, reg_wdata, line_num} = 26'h000_0000;
    {vertical_overflow_bits, vblank_start_low, line_compare_low} = 24'h00_0000;
    seed = 32'h8331_ca0b;
    seed2 = seed;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    put(3'h0, IDX_START_HI, 8'h00, 10'h000, 26'h000_0000, RD);
    for (int i = 7; i < 17; i++) begin
      seed = lfsr(seed);
      msk = i == 8 ? MASK_PRESET : i == 10 ? MASK_CUR_ST : i == 11 ? MASK_CUR_END : 8'hff;
      msk = i > 7 && i < 16 ? msk : 8'h00;
      put(3'h4, 8'(i), seed[7:0], 10'h000, {seed[7:0] & msk, 18'h0_0000}, RD);
    end
    put(3'h4, IDX_MAXSCAN, 8'h63, 10'h000, {8'h63, 18'h0_0000}, RD);
    put(3'h4, IDX_START_HI, seed[15:8], 10'h000, {seed[15:8], 18'h0_0000}, RD);
    put(3'h4, IDX_START_LO, seed[7:0], 10'h000, {seed[7:0], 18'h0_0000}, RD);
    {vertical_overflow_bits, line_compare_low, vblank_start_low} <=
      {seed[23:16], seed[31:24], ~seed[31:24]};
    put(3'h2, 8'h00, 8'h00, 10'h000, {8'h00, seed[15:0], 2'h0}, 26'h003_fffe);
    put(3'h1, 8'h00, 8'h00, {1'b1, seed[20], seed[31:24]} - 10'h001,
      26'h000_0000, 26'h000_0002);
    put(3'h1, 8'h00, 8'h00, {1'b1, seed[20], seed[31:24]}, 26'h2, 26'h003_fffe);
    put(3'h1, 8'h00, 8'h00, {1'b1, seed[19], ~seed[31:24]}, 26'h1, 26'h3);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
